/* File: rsb_pkg.sv */
// package for the reset source and brown-out control block
package rsb_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_THRESH  = 8'h00;
  localparam logic [7:0] ADDR_CAUSE   = 8'h04;
  localparam logic [7:0] ADDR_WDCTL   = 8'h08;
  localparam logic [7:0] ADDR_FLASH1  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h18;
  localparam logic [7:0] ADDR_CTRL    = 8'h1C;

  // threshold codes
  localparam logic [7:0] THR_2V10  = 8'h55;
  localparam logic [7:0] THR_2V55  = 8'h33;
  localparam logic [7:0] THR_3V15  = 8'h99;
  localparam logic [7:0] THR_3V80  = 8'hAA;
  localparam logic [7:0] THR_OFF   = 8'hF0;
  localparam logic [7:0] THR_RESET = 8'h55;

  // watchdog control keys (field at bits 7..3), watchdog reset byte and flash key
  localparam logic [4:0] WD_ENABLE  = 5'h0A;
  localparam logic [4:0] WD_DISABLE = 5'h15;
  localparam logic [7:0] WD_RESET   = 8'h53;
  localparam logic [7:0] FLASH_KEY  = 8'h55;

  // cause flag bit positions
  localparam int CAUSE_BROWNOUT = 2;
  localparam int CAUSE_THRKEY   = 1;
  localparam int CAUSE_WDKEY    = 0;

  // status bits
  localparam int ST_EXPIRY = 0;
  localparam int ST_SLEEP  = 1;

  // interrupt event bits
  localparam int EV_BROWNOUT = 0;
  localparam int EV_THRKEY   = 1;
  localparam int EV_WDKEY    = 2;
  localparam int EV_FLASH    = 3;
  localparam int EV_EXPIRY   = 4;
  localparam int EV_WIDTH    = 5;

  // timing; filter and soft-reset delays counted in low-speed oscillator ticks
  localparam int LS_TICK_NS     = 31250;
  localparam int CLK_NS         = 25;
  localparam int LS_TICK_CYCLES = LS_TICK_NS / CLK_NS;
  localparam int FILTER_TICKS   = 4;
  localparam int SRESET_TICKS   = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    RSB_RUN,
    RSB_DELAY,
    RSB_RESET
  } rsb_state_e;

  typedef struct packed {
    logic full_reset;
    logic pc_sp_clear;
  } rsb_reset_s;
endpackage : rsb_pkg

/* File: rsb_reset_ctrl.sv */
// reset source and brown-out control with an axi4-lite register slave
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module rsb_reset_ctrl #(
  parameter int FILTER_TICKS = rsb_pkg::FILTER_TICKS,
  parameter int SRESET_TICKS = rsb_pkg::SRESET_TICKS
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        supply_low,
  input  wire logic        sleep_mode,
  input  wire logic        wd_expiry,
  input  wire logic        sleep_entry,
  input  wire logic        wd_clear,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       threshold_level,
  output logic             brownout_enable,
  output logic             watchdog_enable,
  output logic             sys_reset,
  output logic             pc_sp_clear,
  output logic             irq
);
  localparam logic [15:0] TICK_MAX = 16'(rsb_pkg::LS_TICK_CYCLES - 1);
  localparam logic [7:0]  FILT_MAX = 8'(FILTER_TICKS);
  localparam logic [7:0]  SRST_MAX = 8'(SRESET_TICKS);

  // input synchronisers, first stage read only by the second
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 5'h0_0;
      sync2_reg <= 5'h0_0;
    end else begin
      sync1_reg <= {wd_clear, sleep_entry, wd_expiry, sleep_mode, supply_low};
      sync2_reg <= sync1_reg;
    end
  end
  wire low_s    = sync2_reg[0];
  wire sleep_s  = sync2_reg[1];
  wire expiry_s = sync2_reg[2];
  wire entry_s  = sync2_reg[3];
  wire wdclr_s  = sync2_reg[4];
  logic expiry_d_reg;
  wire  expiry_ev = expiry_s & ~expiry_d_reg;

  // low-speed tick
  logic [15:0] tick_cnt_reg;
  wire         tick = (tick_cnt_reg == TICK_MAX);

  // registers
  logic [7:0]  thresh_reg;
  logic [2:0]  cause_reg;
  logic [7:0]  wdctl_reg;
  logic [1:0]  status_reg;
  logic [rsb_pkg::EV_WIDTH-1:0] irq_st_reg;
  logic [rsb_pkg::EV_WIDTH-1:0] irq_msk_reg;
  logic [7:0]  filt_cnt_reg;
  logic [7:0]  srst_cnt_reg;
  rsb_pkg::rsb_state_e state_reg;
  rsb_pkg::rsb_reset_s rst_reg;

  // threshold decode
  wire thr_valid = (thresh_reg == rsb_pkg::THR_2V10) | (thresh_reg == rsb_pkg::THR_2V55) |
                   (thresh_reg == rsb_pkg::THR_3V15) | (thresh_reg == rsb_pkg::THR_3V80);
  wire thr_bad   = ~thr_valid & (thresh_reg != rsb_pkg::THR_OFF);
  wire [1:0] thr_level = (thresh_reg == rsb_pkg::THR_2V55) ? 2'h1 :
                         (thresh_reg == rsb_pkg::THR_3V15) ? 2'h2 :
                         (thresh_reg == rsb_pkg::THR_3V80) ? 2'h3 : 2'h0;
  wire mon_on    = thr_valid & ~sleep_s;
  wire [4:0] wd_key = wdctl_reg[7:3];
  wire wd_bad    = (wd_key != rsb_pkg::WD_ENABLE) & (wd_key != rsb_pkg::WD_DISABLE);

  // brown-out filter: low must outlast the filter ticks
  wire brownout_ev = mon_on & low_s & tick & (filt_cnt_reg == FILT_MAX);

  // axi write path
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire wr_b0   = wr_go & w_strb_reg[0];
  wire [7:0] wbyte = w_data_reg[7:0];
  wire wr_thr  = wr_b0 & (aw_addr_reg == rsb_pkg::ADDR_THRESH);
  wire wr_cau  = wr_b0 & (aw_addr_reg == rsb_pkg::ADDR_CAUSE);
  wire wr_wdc  = wr_b0 & (aw_addr_reg == rsb_pkg::ADDR_WDCTL);
  wire wr_fls  = wr_b0 & (aw_addr_reg == rsb_pkg::ADDR_FLASH1);
  wire wr_ist  = wr_b0 & (aw_addr_reg == rsb_pkg::ADDR_IRQ_ST);
  wire wr_msk  = wr_b0 & (aw_addr_reg == rsb_pkg::ADDR_IRQ_MSK);
  wire wr_ok   = (aw_addr_reg[7:5] == 3'h0) & (aw_addr_reg[1:0] == 2'h0);
  wire flash_ev = wr_fls & (wbyte == rsb_pkg::FLASH_KEY);

  // soft-reset delay runs for a bad key; full events trigger at once
  wire soft_req   = thr_bad | wd_bad;
  wire soft_done  = (state_reg == rsb_pkg::RSB_DELAY) & tick & (srst_cnt_reg == SRST_MAX);
  wire run_expiry = expiry_ev & ~sleep_s;
  wire full_now   = brownout_ev | flash_ev | run_expiry | soft_done;

  wire [rsb_pkg::EV_WIDTH-1:0] events = {expiry_ev, flash_ev,
                                         soft_done & wd_bad, soft_done & thr_bad, brownout_ev};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= 16'h0000;
      expiry_d_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      expiry_d_reg <= expiry_s;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      filt_cnt_reg <= 8'h00;
    end else if (!(mon_on & low_s)) begin
      filt_cnt_reg <= 8'h00;
    end else if (tick & (filt_cnt_reg != FILT_MAX)) begin
      filt_cnt_reg <= filt_cnt_reg + 8'h01;
    end
  end

  // reset sequencer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= rsb_pkg::RSB_RUN;
      srst_cnt_reg <= 8'h00;
      rst_reg      <= '0;
    end else begin
      rst_reg.full_reset  <= full_now;
      rst_reg.pc_sp_clear <= full_now | (expiry_ev & sleep_s);
      unique case (state_reg)
        rsb_pkg::RSB_RUN: begin
          srst_cnt_reg <= 8'h00;
          if (soft_req) begin
            state_reg <= rsb_pkg::RSB_DELAY;
          end
        end
        rsb_pkg::RSB_DELAY: begin
          if (soft_done) begin
            state_reg <= rsb_pkg::RSB_RESET;
          end else if (tick) begin
            srst_cnt_reg <= srst_cnt_reg + 8'h01;
          end
        end
        rsb_pkg::RSB_RESET: begin
          state_reg <= rsb_pkg::RSB_RUN;
        end
      endcase
    end
  end

  // software registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      thresh_reg  <= rsb_pkg::THR_RESET;
      wdctl_reg   <= rsb_pkg::WD_RESET;
      cause_reg   <= 3'h0;
      status_reg  <= 2'h0;
      irq_st_reg  <= '0;
      irq_msk_reg <= '0;
    end else begin
      // a bad code is restored; a brown-out keeps the contents
      if (soft_done & thr_bad) begin
        thresh_reg <= rsb_pkg::THR_RESET;
      end else if (wr_thr) begin
        thresh_reg <= wbyte;
      end
      if (soft_done & wd_bad) begin
        wdctl_reg <= rsb_pkg::WD_RESET;
      end else if (wr_wdc) begin
        wdctl_reg <= wbyte;
      end
      // set wins over a software clear
      cause_reg[rsb_pkg::CAUSE_BROWNOUT] <= brownout_ev |
        (cause_reg[rsb_pkg::CAUSE_BROWNOUT] & ~(wr_cau & ~wbyte[rsb_pkg::CAUSE_BROWNOUT]));
      cause_reg[rsb_pkg::CAUSE_THRKEY] <= (soft_done & thr_bad) |
        (cause_reg[rsb_pkg::CAUSE_THRKEY] & ~(wr_cau & ~wbyte[rsb_pkg::CAUSE_THRKEY]));
      cause_reg[rsb_pkg::CAUSE_WDKEY] <= (soft_done & wd_bad) |
        (cause_reg[rsb_pkg::CAUSE_WDKEY] & ~(wr_cau & ~wbyte[rsb_pkg::CAUSE_WDKEY]));
      // brown-out leaves both flags alone
      status_reg[rsb_pkg::ST_EXPIRY] <= expiry_ev |
        (status_reg[rsb_pkg::ST_EXPIRY] & ~wdclr_s);
      status_reg[rsb_pkg::ST_SLEEP] <= entry_s | (expiry_ev & sleep_s) |
        (status_reg[rsb_pkg::ST_SLEEP] & ~wdclr_s);
      irq_st_reg <= events | (irq_st_reg & ~({rsb_pkg::EV_WIDTH{wr_ist}} &
                                             wbyte[rsb_pkg::EV_WIDTH-1:0]));
      if (wr_msk) begin
        irq_msk_reg <= wbyte[rsb_pkg::EV_WIDTH-1:0];
      end
    end
  end

  // axi handshakes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= rsb_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_hold_reg & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold_reg & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? rsb_pkg::RESP_OKAY : rsb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux, upper bits zero
  wire [7:0] rd_byte =
    (s_axi_araddr == rsb_pkg::ADDR_THRESH)  ? thresh_reg :
    (s_axi_araddr == rsb_pkg::ADDR_CAUSE)   ? {5'h00, cause_reg} :
    (s_axi_araddr == rsb_pkg::ADDR_WDCTL)   ? wdctl_reg :
    (s_axi_araddr == rsb_pkg::ADDR_STATUS)  ? {6'h00, status_reg} :
    (s_axi_araddr == rsb_pkg::ADDR_IRQ_ST)  ? {3'h0, irq_st_reg} :
    (s_axi_araddr == rsb_pkg::ADDR_IRQ_MSK) ? {3'h0, irq_msk_reg} :
    (s_axi_araddr == rsb_pkg::ADDR_CTRL)    ? {4'h0, mon_on, thr_level, thr_bad} : 8'h00;
  wire rd_ok = (s_axi_araddr[7:5] == 3'h0) & (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= rsb_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_ok ? rsb_pkg::RESP_OKAY : rsb_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // outputs straight from flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      threshold_level <= 2'h0;
      brownout_enable <= 1'b0;
      watchdog_enable <= 1'b0;
      sys_reset       <= 1'b1;
      pc_sp_clear     <= 1'b1;
      irq             <= 1'b0;
    end else begin
      threshold_level <= thr_level;
      brownout_enable <= mon_on;
      watchdog_enable <= (wd_key == rsb_pkg::WD_ENABLE);
      sys_reset       <= rst_reg.full_reset;
      pc_sp_clear     <= rst_reg.pc_sp_clear;
      irq             <= |(irq_st_reg & irq_msk_reg);
    end
  end

  a_brownout_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
    brownout_ev |=> cause_reg[rsb_pkg::CAUSE_BROWNOUT])
    else $error("brownout flag not set");
  a_short_low_ignored: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !low_s |=> !brownout_ev)
    else $error("brownout without filter");
  a_sleep_no_monitor: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sleep_s |=> !brownout_enable)
    else $error("monitor active in sleep");
  a_bad_code_restore: assert property (@(posedge clk_sys) disable iff (!arst_n)
    soft_done && thr_bad |=> thresh_reg == rsb_pkg::THR_RESET && cause_reg[rsb_pkg::CAUSE_THRKEY])
    else $error("bad threshold not restored");
  a_keep_on_brownout: assert property (@(posedge clk_sys) disable iff (!arst_n)
    brownout_ev && !wr_thr |=> $stable(thresh_reg))
    else $error("threshold changed");
  a_flash_reset: assert property (@(posedge clk_sys) disable iff (!arst_n)
    flash_ev |-> ##2 sys_reset)
    else $error("flash key reset missing");
  a_sleep_expiry: assert property (@(posedge clk_sys) disable iff (!arst_n)
    expiry_ev && sleep_s && !full_now |-> ##1 status_reg == 2'h3 ##1 pc_sp_clear && !sys_reset)
    else $error("sleep expiry wrong");
  a_run_expiry: assert property (@(posedge clk_sys) disable iff (!arst_n)
    expiry_ev && !sleep_s |-> ##2 sys_reset)
    else $error("run expiry no reset");
  a_wd_key_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
    soft_done && wd_bad |=> cause_reg[rsb_pkg::CAUSE_WDKEY])
    else $error("wd key flag");
  a_cause_sticky: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cause_reg[rsb_pkg::CAUSE_BROWNOUT] && !wr_cau |=> cause_reg[rsb_pkg::CAUSE_BROWNOUT])
    else $error("cause flag lost");
  a_status_kept: assert property (@(posedge clk_sys) disable iff (!arst_n)
    brownout_ev && !expiry_ev && !entry_s && !wdclr_s |=> $stable(status_reg))
    else $error("brownout changed status");
endmodule : rsb_reset_ctrl

`default_nettype wire

/* File: test_rsb_reset_ctrl.sv */
// self-checking bench for the reset source and brown-out control block
`timescale 1ns/1ps
`default_nettype none
module test_rsb_reset_ctrl;
  // short counts keep the run small; expectations use these values
  localparam int FT = 1 + 1;
  localparam int ST = 1;
  localparam int TK = rsb_pkg::LS_TICK_CYCLES;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic        supply_low = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        wd_expiry = 1'b0;
  logic        sleep_entry = 1'b0;
  logic        wd_clear = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic [1:0]  threshold_level;
  logic        brownout_enable;
  logic        watchdog_enable;
  logic        sys_reset;
  logic        pc_sp_clear;
  logic        irq;
  int          fails = 0;
  int          checks = 0;
  int          nrst = 0;
  int          npc = 0;
  int          n0;
  int          p0;
  logic [31:0] v;
  logic [1:0]  r;
  logic [7:0]  codes [4] = '{rsb_pkg::THR_2V10, rsb_pkg::THR_2V55, rsb_pkg::THR_3V15,
                             rsb_pkg::THR_3V80};

  always #12.5 clk_sys = ~clk_sys;

  rsb_reset_ctrl #(.FILTER_TICKS(FT), .SRESET_TICKS(ST)) i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .supply_low(supply_low), .sleep_mode(sleep_mode),
    .wd_expiry(wd_expiry), .sleep_entry(sleep_entry), .wd_clear(wd_clear),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .threshold_level(threshold_level), .brownout_enable(brownout_enable),
    .watchdog_enable(watchdog_enable), .sys_reset(sys_reset), .pc_sp_clear(pc_sp_clear),
    .irq(irq));

  // reset pulses are counted as they pass; tests compare deltas
  always @(posedge clk_sys) begin
    if (arst_n && sys_reset) nrst <= nrst + 1;
    if (arst_n && pc_sp_clear) npc <= npc + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    // one more edge so registered outputs already show the write
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, v, r);
    chk(v, exp);
  endtask

  // expiry event held a few cycles so the synchroniser sees one edge
  task automatic expire();
    wd_expiry <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wd_expiry <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic stop_test();
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    rchk(rsb_pkg::ADDR_THRESH, 32'h0000_0055);
    rchk(rsb_pkg::ADDR_CAUSE, 32'h0000_0000);
    rchk(rsb_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(32'(watchdog_enable), 32'h0000_0001);
    chk(32'(brownout_enable), 32'h0000_0001);
    rd(8'h20, v, r);
    chk(32'(r), 32'(rsb_pkg::RESP_SLVERR));
    // unmapped write: error response and no effect
    wr(8'h20, 32'h0000_0012);
    chk(32'(r), 32'(rsb_pkg::RESP_SLVERR));
    rchk(rsb_pkg::ADDR_THRESH, 32'h0000_0055);
    for (int i = 0; i < 4; i++) begin
      wr(rsb_pkg::ADDR_THRESH, {24'h00_0000, codes[i]});
      chk(32'(r), 32'(rsb_pkg::RESP_OKAY));
      rchk(rsb_pkg::ADDR_THRESH, {24'h00_0000, codes[i]});
      chk(32'(threshold_level), 32'(i));
    end
    rchk(rsb_pkg::ADDR_CTRL, 32'h0000_000E);
    wr(rsb_pkg::ADDR_THRESH, {24'h00_0000, rsb_pkg::THR_OFF});
    chk(32'(brownout_enable), 32'h0000_0000);
    wr(rsb_pkg::ADDR_THRESH, {24'h00_0000, rsb_pkg::THR_2V55});
    sleep_mode <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(32'(brownout_enable), 32'h0000_0000);
    sleep_mode <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(32'(brownout_enable), 32'h0000_0001);
    sleep_entry <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sleep_entry <= 1'b0;
    wr(rsb_pkg::ADDR_IRQ_MSK, 32'h0000_0001);
    n0 = nrst;
    supply_low <= 1'b1;
    repeat (TK) @(posedge clk_sys);
    supply_low <= 1'b0;
    repeat (2 * TK) @(posedge clk_sys);
    chk(32'(nrst - n0), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    supply_low <= 1'b1;
    repeat ((FT + 3) * TK) @(posedge clk_sys);
    supply_low <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(32'(nrst > n0), 32'h0000_0001);
    rchk(rsb_pkg::ADDR_CAUSE, 32'h0000_0004);
    rchk(rsb_pkg::ADDR_THRESH, 32'h0000_0033);
    rchk(rsb_pkg::ADDR_STATUS, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001);
    wr(rsb_pkg::ADDR_CAUSE, 32'h0000_0004);
    rchk(rsb_pkg::ADDR_CAUSE, 32'h0000_0004);
    wr(rsb_pkg::ADDR_CAUSE, 32'h0000_0000);
    rchk(rsb_pkg::ADDR_CAUSE, 32'h0000_0000);
    wr(rsb_pkg::ADDR_IRQ_ST, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    // masked event: status bit set, line stays low
    wr(rsb_pkg::ADDR_IRQ_MSK, 32'h0000_0000);
    n0 = nrst;
    wr(rsb_pkg::ADDR_THRESH, 32'h0000_0012);
    repeat ((ST + 3) * TK) @(posedge clk_sys);
    chk(32'(nrst > n0), 32'h0000_0001);
    rchk(rsb_pkg::ADDR_THRESH, 32'h0000_0055);
    rchk(rsb_pkg::ADDR_CAUSE, 32'h0000_0002);
    rchk(rsb_pkg::ADDR_IRQ_ST, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0000);
    wr(rsb_pkg::ADDR_CAUSE, 32'h0000_0000);
    n0 = nrst;
    wr(rsb_pkg::ADDR_WDCTL, 32'h0000_0000);
    repeat ((ST + 3) * TK) @(posedge clk_sys);
    chk(32'(nrst > n0), 32'h0000_0001);
    rchk(rsb_pkg::ADDR_CAUSE, 32'h0000_0001);
    wr(rsb_pkg::ADDR_WDCTL, 32'h0000_00A8);
    chk(32'(watchdog_enable), 32'h0000_0000);
    n0 = nrst;
    wr(rsb_pkg::ADDR_FLASH1, 32'h0000_0055);
    repeat (8) @(posedge clk_sys);
    chk(32'(nrst - n0), 32'h0000_0001);
    rchk(rsb_pkg::ADDR_FLASH1, 32'h0000_0000);
    wd_clear <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wd_clear <= 1'b0;
    rchk(rsb_pkg::ADDR_STATUS, 32'h0000_0000);
    n0 = nrst;
    expire();
    chk(32'(nrst - n0), 32'h0000_0001);
    rchk(rsb_pkg::ADDR_STATUS, 32'h0000_0001);
    sleep_mode <= 1'b1;
    repeat (8) @(posedge clk_sys);
    n0 = nrst;
    p0 = npc;
    expire();
    chk(32'(nrst - n0), 32'h0000_0000);
    chk(32'(npc - p0), 32'h0000_0001);
    rchk(rsb_pkg::ADDR_STATUS, 32'h0000_0003);
    sleep_mode <= 1'b0;
    repeat (8) @(posedge clk_sys);
    // key-error, flash and expiry events all left in the status
    rchk(rsb_pkg::ADDR_IRQ_ST, 32'h0000_001E);
    wr(rsb_pkg::ADDR_THRESH, {24'h00_0000, rsb_pkg::THR_3V15});
    // second power-on in mid-run
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(32'({sys_reset, pc_sp_clear}), 32'h0000_0003);
    arst_n <= 1'b1;
    rchk(rsb_pkg::ADDR_STATUS, 32'h0000_0000);
    rchk(rsb_pkg::ADDR_THRESH, 32'h0000_0055);
    rchk(rsb_pkg::ADDR_IRQ_ST, 32'h0000_0000);
    chk(32'(watchdog_enable), 32'h0000_0001);
    stop_test();
  end
endmodule // test_rsb_reset_ctrl
`default_nettype wire
